// >>> shared/cbe_pkg.sv
// Package for the conditional branch evaluator: opcodes, flags, timing
`default_nettype none
package cbe_pkg;
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    // Branch condition codes presented by the instruction decoder
    typedef enum logic [3:0] {
        jump_on_carry_set = 4'h0,
        jump_on_carry_clear = 4'h1,
        jump_unsigned_at_least = 4'h2,
        jump_unsigned_below = 4'h3,
        jump_on_negative = 4'h4,
        jump_on_nonnegative = 4'h5,
        jump_signed_at_least = 4'h6,
        jump_signed_below = 4'h7,
        jump_on_nibble_carry_set = 4'h8,
        jump_on_nibble_carry_clear = 4'h9,
        jump_on_spare_bit_set = 4'hA,
        jump_on_spare_bit_clear = 4'hB
    } cbe_cond_t;
    // Status flags consulted by the branches
    typedef struct packed {
        logic spare;
        logic nibble_carry;
        logic overflow;
        logic negative;
        logic carry;
    } cbe_flags_t;
    // One decoded branch request
    typedef struct packed {
        logic valid;
        cbe_cond_t cond;
        logic [OFS_W-1:0] offset;
    } cbe_req_t;
    localparam int TAKEN_CYCLES = 2;
    localparam int FAIL_CYCLES = 1;
endpackage
`default_nettype wire

// >>> src/cbe_branch_eval.sv
// Conditional relative branch evaluator with program counter update
`default_nettype none
module cbe_branch_eval
    import cbe_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire cbe_req_t req, // Branch request from decoder
    input wire cbe_flags_t flags, // Status flags, same clock
    output logic [PC_W-1:0] program_counter, // Current PC
    output logic busy, // Second cycle of a taken branch
    output logic flush, // Discard fetched successor
    output logic taken, // Branch taken this request
    output cbe_flags_t flags_out // Flags after the branch
);
    typedef enum {S_IDLE, S_DISCARD} cbe_state_t;
    cbe_state_t state_r;
    logic cond_met;
    logic accept;
    logic [PC_W-1:0] target;

    // One clock domain: every check below samples here
    default clocking cbe_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Shared condition decode
    function automatic logic cbe_test(cbe_cond_t c, cbe_flags_t f);
        logic r;
        r = 1'b0;
        case (c)
            jump_on_carry_set: r = f.carry;
            jump_on_carry_clear: r = ~f.carry;
            jump_unsigned_at_least: r = ~f.carry;
            jump_unsigned_below: r = f.carry;
            jump_on_negative: r = f.negative;
            jump_on_nonnegative: r = ~f.negative;
            jump_signed_at_least: r = ~(f.negative ^ f.overflow);
            jump_signed_below: r = f.negative ^ f.overflow;
            jump_on_nibble_carry_set: r = f.nibble_carry;
            jump_on_nibble_carry_clear: r = ~f.nibble_carry;
            jump_on_spare_bit_set: r = f.spare;
            jump_on_spare_bit_clear: r = ~f.spare;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Requests arriving during the discard cycle are the dead successor
    assign accept = req.valid && (state_r == S_IDLE);
    assign cond_met = cbe_test(req.cond, flags);
    assign target = program_counter + PC_STEP
        + {{(PC_W-OFS_W){req.offset[OFS_W-1]}}, req.offset};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= S_IDLE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (accept && cond_met) begin
                        state_r <= S_DISCARD;
                    end
                end
                S_DISCARD: state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            program_counter <= PC_RESET;
        end else if (accept && cond_met) begin
            program_counter <= target;
        end else if (accept) begin
            program_counter <= program_counter + PC_STEP;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            flush <= 1'b0;
            taken <= 1'b0;
        end else begin
            busy <= accept && cond_met;
            flush <= accept && cond_met;
            taken <= accept && cond_met;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_out <= '0;
        end else begin
            flags_out <= flags;
        end
    end

    // Assertions; outcome checks judge the registered taken output, except the unsigned and signed compares, which check cond_met

    taken_pc_a: assert property (
        accept && cond_met |=> program_counter == $past(target))
        else $error("taken branch PC wrong");
    fall_pc_a: assert property (
        accept && !cond_met
        |=> program_counter == $past(program_counter) + PC_STEP)
        else $error("fall-through PC wrong");
    carry_set_a: assert property (
        accept && req.cond == jump_on_carry_set
        |=> taken == $past(flags.carry))
        else $error("carry set branch outcome wrong");
    carry_clear_a: assert property (
        accept && req.cond == jump_on_carry_clear
        |=> taken == !$past(flags.carry))
        else $error("carry clear branch outcome wrong");
    unsigned_ge_a: assert property (
        accept && req.cond == jump_unsigned_at_least
        |-> cond_met == !flags.carry)
        else $error("unsigned at-least decode wrong");
    unsigned_lt_a: assert property (
        accept && req.cond == jump_unsigned_below
        |-> cond_met == flags.carry)
        else $error("unsigned below decode wrong");
    negative_set_a: assert property (
        accept && req.cond == jump_on_negative
        |=> taken == $past(flags.negative))
        else $error("negative branch outcome wrong");
    negative_clear_a: assert property (
        accept && req.cond == jump_on_nonnegative
        |=> taken == !$past(flags.negative))
        else $error("non-negative branch outcome wrong");
    signed_ge_a: assert property (
        accept && req.cond == jump_signed_at_least
        |-> cond_met == (flags.negative == flags.overflow))
        else $error("signed at-least decode wrong");
    signed_lt_a: assert property (
        accept && req.cond == jump_signed_below
        |-> cond_met != (flags.negative == flags.overflow))
        else $error("signed below decode wrong");
    nibble_set_a: assert property (
        accept && req.cond == jump_on_nibble_carry_set
        |=> taken == $past(flags.nibble_carry))
        else $error("nibble carry set outcome wrong");
    nibble_clear_a: assert property (
        accept && req.cond == jump_on_nibble_carry_clear
        |=> taken == !$past(flags.nibble_carry))
        else $error("nibble carry clear outcome wrong");
    spare_set_a: assert property (
        accept && req.cond == jump_on_spare_bit_set
        |=> taken == $past(flags.spare))
        else $error("spare bit set outcome wrong");
    spare_clear_a: assert property (
        accept && req.cond == jump_on_spare_bit_clear
        |=> taken == !$past(flags.spare))
        else $error("spare bit clear outcome wrong");
    flags_kept_a: assert property (
        1'b1 |=> flags_out == $past(flags))
        else $error("branch changed a flag");
    two_cycle_a: assert property (
        accept && cond_met |=> busy ##1 !busy)
        else $error("taken branch not two cycles");
    fall_one_a: assert property (
        accept && !cond_met |=> !busy && !taken)
        else $error("failed branch used a discard cycle");
    discard_hold_a: assert property (
        busy |=> $stable(program_counter))
        else $error("PC moved in discard cycle");
    refuse_a: assert property (
        busy && req.valid |=> !taken && !busy)
        else $error("successor in discard cycle was taken");

    // Main scenarios reached
    taken_c: cover property (accept && cond_met);
    fail_c: cover property (accept && !cond_met);
    back_c: cover property (accept && cond_met ##2 accept && cond_met);
    refuse_c: cover property (busy && req.valid);
    odd_code_c: cover property (accept && req.cond > jump_on_spare_bit_clear);
endmodule
`default_nettype wire

// >>> tb/cbe_tb.sv
// Self-checking testbench for the conditional branch evaluator
`default_nettype none
module tb
    import cbe_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    cbe_req_t req = '0;
    cbe_flags_t flags = '0;
    logic [PC_W-1:0] program_counter;
    logic busy;
    logic flush;
    logic taken;
    cbe_flags_t flags_out;
    logic [PC_W-1:0] model_pc = PC_RESET;
    int errors = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    cbe_branch_eval cbe_branch_eval_i (.clk(clk), .reset_n(reset_n),
        .req(req), .flags(flags), .program_counter(program_counter),
        .busy(busy), .flush(flush), .taken(taken), .flags_out(flags_out));
    task automatic chk(input string what, input logic [PC_W-1:0] exp,
                       input logic [PC_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Flags held through the request so flags_out can be judged
    task automatic br(input cbe_cond_t c, input cbe_flags_t f,
                      input logic [OFS_W-1:0] o, input logic hit);
        @(posedge clk);
        req <= '{1'b1, c, o};
        flags <= f;
        @(posedge clk);
        req.valid <= 1'b0;
        model_pc = model_pc + (hit ?
            {{(PC_W-OFS_W){o[OFS_W-1]}}, o} + PC_STEP : PC_STEP);
        #1;
        chk("program_counter", model_pc, program_counter);
        chk("taken", hit, taken);
        chk("busy", hit, busy);
        chk("flush", hit, flush);
        chk("flags_out", f, flags_out);
        if (hit) @(posedge clk);
    endtask
    task automatic t_carry();
        br(jump_on_carry_set, 5'h01, 7'h03, 1'b1);
        br(jump_on_carry_set, 5'h1E, 7'h03, 1'b0);
        br(jump_on_carry_clear, 5'h1E, 7'h07, 1'b1);
        br(jump_on_carry_clear, 5'h01, 7'h07, 1'b0);
        br(jump_unsigned_at_least, 5'h00, 7'h7E, 1'b1);
        br(jump_unsigned_at_least, 5'h01, 7'h7E, 1'b0);
        br(jump_unsigned_below, 5'h01, 7'h12, 1'b1);
        br(jump_unsigned_below, 5'h1E, 7'h12, 1'b0);
    endtask
    task automatic t_negative();
        br(jump_on_negative, 5'h02, 7'h21, 1'b1);
        br(jump_on_negative, 5'h1D, 7'h21, 1'b0);
        br(jump_on_nonnegative, 5'h1D, 7'h70, 1'b1);
        br(jump_on_nonnegative, 5'h02, 7'h70, 1'b0);
    endtask
    task automatic t_signed();
        br(jump_signed_at_least, 5'h06, 7'h09, 1'b1);
        br(jump_signed_at_least, 5'h00, 7'h09, 1'b1);
        br(jump_signed_at_least, 5'h02, 7'h09, 1'b0);
        br(jump_signed_below, 5'h04, 7'h66, 1'b1);
        br(jump_signed_below, 5'h02, 7'h66, 1'b1);
        br(jump_signed_below, 5'h06, 7'h66, 1'b0);
    endtask
    task automatic t_nibble_spare();
        br(jump_on_nibble_carry_set, 5'h08, 7'h0A, 1'b1);
        br(jump_on_nibble_carry_set, 5'h17, 7'h0A, 1'b0);
        br(jump_on_nibble_carry_clear, 5'h17, 7'h55, 1'b1);
        br(jump_on_nibble_carry_clear, 5'h08, 7'h55, 1'b0);
        br(jump_on_spare_bit_set, 5'h10, 7'h2C, 1'b1);
        br(jump_on_spare_bit_set, 5'h0F, 7'h2C, 1'b0);
        br(jump_on_spare_bit_clear, 5'h0F, 7'h4B, 1'b1);
        br(jump_on_spare_bit_clear, 5'h10, 7'h4B, 1'b0);
    endtask
    task automatic t_edges();
        br(jump_on_carry_set, 5'h01, 7'h40, 1'b1);
        br(jump_on_carry_set, 5'h01, 7'h3F, 1'b1);
        br(jump_on_negative, 5'h02, 7'h7F, 1'b1);
        br(cbe_cond_t'(4'hC), 5'h1F, 7'h11, 1'b0);
    endtask
    // Successor presented in the discard cycle must be dropped
    task automatic t_refuse();
        @(posedge clk);
        req <= '{1'b1, jump_on_carry_set, 7'h05};
        flags <= 5'h01;
        @(posedge clk);
        req.offset <= 7'h10;
        model_pc = model_pc + 16'h0006;
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk("program_counter", model_pc, program_counter);
        chk("taken", 1'b0, taken);
        chk("busy", 1'b0, busy);
        chk("flush", 1'b0, flush);
    endtask
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("program_counter", PC_RESET, program_counter);
        chk("busy", 1'b0, busy);
        chk("flush", 1'b0, flush);
        chk("taken", 1'b0, taken);
        chk("flags_out", 5'h00, flags_out);
        t_carry();
        t_negative();
        t_signed();
        t_nibble_spare();
        t_refuse();
        t_edges();
        conclude();
    end
endmodule
`default_nettype wire
